// [core/seq_status_pkg.sv]
// package: register map, field layout and carriers for the sequencer status and otp bank
package seq_status_pkg;

   localparam int          NUM_EN        = 12;
   localparam int          NUM_UPPER     = 4;
   localparam int          NUM_LOWER     = 8;
   localparam int          NUM_EVT       = 5;

   // register byte addresses
   localparam logic [11:0] PIN_STATUS_ADDR   = 12'h000;
   localparam logic [11:0] ENABLE_DRIVE_ADDR = 12'h004;
   localparam logic [11:0] WDOG_BIST_ADDR    = 12'h008;
   localparam logic [11:0] OTP_CONFIG_ADDR   = 12'h00c;
   localparam logic [11:0] INT_STATUS_ADDR   = 12'h010;
   localparam logic [11:0] INT_MASK_ADDR     = 12'h014;

   // pin status fields
   localparam int PS_IRQ_BIT    = 0;
   localparam int PS_RST_BIT    = 1;
   localparam int PS_SLEEP_BIT  = 2;
   localparam int PS_ACT_BIT    = 3;
   localparam int PS_SEQ_LSB    = 4;

   // enable drive fields
   localparam int ED_LOWER_LSB  = 0;
   localparam int ED_UPPER_LSB  = 8;

   // watchdog and self-test fields
   localparam int WB_OPEN_BIT   = 0;
   localparam int WB_EARLY_BIT  = 1;
   localparam int WB_EXP_BIT    = 2;
   localparam int WB_DONE_BIT   = 3;
   localparam int WB_ECC_BIT    = 4;
   localparam int WB_VM_BIT     = 5;
   localparam int WB_NVM_BIT    = 6;
   localparam int WB_LOGIC_BIT  = 7;
   localparam int WB_ANALOG_BIT = 8;

   // otp fields
   localparam int OT_ENTYPE_LSB = 0;
   localparam int OT_XTAL_BIT   = 12;
   localparam int OT_CLKPP_BIT  = 13;

   // interrupt status / mask fields
   localparam int EV_EARLY      = 0;
   localparam int EV_EXPIRED    = 1;
   localparam int EV_ECC        = 2;
   localparam int EV_DONE       = 3;
   localparam int EV_FAIL       = 4;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [NUM_EVT-1:0] MASK_RESET = 5'h00;

   typedef enum logic [2:0] {
      SEQ_SHUTDOWN    = 3'h0,
      SEQ_POWER_UP    = 3'h1,
      SEQ_POWER_DOWN  = 3'h2,
      SEQ_SLEEP       = 3'h3,
      SEQ_SLEEP_ENTRY = 3'h4,
      SEQ_SLEEP_EXIT  = 3'h5,
      SEQ_INVALID     = 3'h6,
      SEQ_ACTIVE      = 3'h7
   } seq_state_e;

   // live state of the power_sequencer, same clock
   typedef struct packed {
      seq_state_e          sequencerState;
      logic [NUM_EN-1:0]   enableDrive;
      logic                irqAsserted;
      logic                rstAsserted;
   } seq_live_s;

   // watchdog events and levels, same clock
   typedef struct packed {
      logic windowOpen;
      logic servicePulse;
      logic closeExpired;
   } wdog_live_s;

   // self-test and nvm read results, same clock
   typedef struct packed {
      logic startPulse;
      logic finishPulse;
      logic volatileFail;
      logic nonvolatileFail;
      logic logicFail;
      logic analogFail;
      logic eccCorrected;
   } selftest_live_s;

   // one-time-programmed configuration
   typedef struct packed {
      logic [NUM_EN-1:0] enableDriverType;
      logic              crystalLoadSelect;
      logic              slowclkDriverType;
   } otp_cfg_s;

endpackage : seq_status_pkg

// [core/seq_status_bank.sv]
// sequencer status and otp bit bank with apb register access
//
// How it works
// - irq_pin_state reads whether interrupt_out_n is currently asserted.
// - reset_pin_state reads whether reset_out_n is asserted, refreshed every cycle.
// - sleep_input_level reads the synchronised sleep request pin level.
// - activate_input_level reads the synchronised activate_input pin level.
// - sequencer_state field encodes shutdown through active plus an invalid code.
// - enable_drive_upper holds outputs 12..9, enable_drive_lower outputs 8..1.
// - watchdog window bit reads open or closed live.
// - wdog_early_service sets when serviced while the window is closed.
// - wdog_timer_expired reads whether the close timer has expired.
// - selftest_done reads one only after self-test has finished.
// - ecc bit shows single-error correction applied on nvm read.
// - separate volatile and nonvolatile self-test pass/fail bits.
// - logic self-test failure reported and drives interrupt and reset requests.
// - analog self-test failure reported and drives interrupt and reset requests.
// - each rail_enable_output driver is open-drain or push-pull per otp bit.
// - crystal load is external or internal per otp bit.
// - slow_clock_output driver is open-drain or push-pull per otp bit.
//
// The implementer's own choices: the APB register port and the register addresses.
module seq_status_bank #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic                                 ref_clk,
   input  wire logic                                 resetn,
   // apb slave
   input  wire logic                                 psel,
   input  wire logic                                 penable,
   input  wire logic                                 pwrite,
   input  wire logic [ADDR_W-1:0]                    paddr,
   input  wire logic [31:0]                          pwdata,
   output logic      [31:0]                          prdata,
   output logic                                      pready,
   output logic                                      pslverr,
   // live sequencer, watchdog and self-test state
   input  wire seq_status_pkg::seq_live_s            seqLive,
   input  wire seq_status_pkg::wdog_live_s           wdogLive,
   input  wire seq_status_pkg::selftest_live_s       selftestLive,
   input  wire seq_status_pkg::otp_cfg_s             otpCfg,
   // asynchronous pins
   input  wire logic                                 sleepPin,
   input  wire logic                                 activatePin,
   input  wire logic                                 slowClkIn,
   // pad controls
   output logic      [seq_status_pkg::NUM_EN-1:0]    railEnOut,
   output logic      [seq_status_pkg::NUM_EN-1:0]    railEnOeN,
   output logic                                      slowClkOut,
   output logic                                      slowClkOeN,
   output logic                                      xtalInternalLoad,
   // fault requests and interrupt
   output logic                                      selftestIrqReq,
   output logic                                      selftestRstReq,
   output logic                                      irqOut
);
   import seq_status_pkg::*;

   // pin synchronisers: first stage is only read by the second
   logic [1:0] sleepSync_ff;
   logic [1:0] actSync_ff;
   logic [1:0] nxt_sleepSync;
   logic [1:0] nxt_actSync;

   always_comb begin
      nxt_sleepSync = {sleepSync_ff[0], sleepPin};
      nxt_actSync   = {actSync_ff[0], activatePin};
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sleepSync_ff <= 2'h0;
         actSync_ff   <= 2'h0;
      end else begin
         sleepSync_ff <= nxt_sleepSync;
         actSync_ff   <= nxt_actSync;
      end
   end

   // live status capture
   logic [31:0] pinStatus_ff;
   logic [31:0] enDrive_ff;
   logic [31:0] nxt_pinStatus;
   logic [31:0] nxt_enDrive;

   always_comb begin
      nxt_pinStatus                        = RESET_WORD;
      nxt_pinStatus[PS_IRQ_BIT]            = seqLive.irqAsserted;
      nxt_pinStatus[PS_RST_BIT]            = seqLive.rstAsserted;
      nxt_pinStatus[PS_SLEEP_BIT]          = sleepSync_ff[1];
      nxt_pinStatus[PS_ACT_BIT]            = actSync_ff[1];
      nxt_pinStatus[PS_SEQ_LSB +: $bits(seq_state_e)] = seqLive.sequencerState;
      nxt_enDrive                          = RESET_WORD;
      nxt_enDrive[ED_LOWER_LSB +: NUM_LOWER] = seqLive.enableDrive[NUM_LOWER-1:0];
      nxt_enDrive[ED_UPPER_LSB +: NUM_UPPER] = seqLive.enableDrive[NUM_EN-1:NUM_LOWER];
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pinStatus_ff <= RESET_WORD;
         enDrive_ff   <= RESET_WORD;
      end else begin
         pinStatus_ff <= nxt_pinStatus;
         enDrive_ff   <= nxt_enDrive;
      end
   end

   // watchdog status
   logic wdOpen_ff;
   logic wdEarly_ff;
   logic wdExpired_ff;
   logic nxt_wdOpen;
   logic nxt_wdEarly;
   logic nxt_wdExpired;
   logic earlyEvt;

   always_comb begin
      nxt_wdOpen    = wdogLive.windowOpen;
      nxt_wdExpired = wdogLive.closeExpired;
      earlyEvt      = wdogLive.servicePulse & ~wdogLive.windowOpen;
      // held until the next in-window service so software can still see it
      nxt_wdEarly   = wdEarly_ff;
      if (earlyEvt) begin
         nxt_wdEarly = 1'b1;
      end else if (wdogLive.servicePulse) begin
         nxt_wdEarly = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         wdOpen_ff    <= 1'b0;
         wdEarly_ff   <= 1'b0;
         wdExpired_ff <= 1'b0;
      end else begin
         wdOpen_ff    <= nxt_wdOpen;
         wdEarly_ff   <= nxt_wdEarly;
         wdExpired_ff <= nxt_wdExpired;
      end
   end

   // self-test results, latched at finish; only the done bit is cleared at start
   logic stDone_ff;
   logic stVm_ff;
   logic stNvm_ff;
   logic stLogic_ff;
   logic stAnalog_ff;
   logic eccSec_ff;
   logic nxt_stDone;
   logic nxt_stVm;
   logic nxt_stNvm;
   logic nxt_stLogic;
   logic nxt_stAnalog;
   logic nxt_eccSec;

   always_comb begin
      nxt_stDone   = stDone_ff;
      nxt_stVm     = stVm_ff;
      nxt_stNvm    = stNvm_ff;
      nxt_stLogic  = stLogic_ff;
      nxt_stAnalog = stAnalog_ff;
      nxt_eccSec   = eccSec_ff;
      if (selftestLive.startPulse) begin
         nxt_stDone = 1'b0;
      end
      // finish wins if both arrive together: the run has ended
      if (selftestLive.finishPulse) begin
         nxt_stDone   = 1'b1;
         nxt_stVm     = selftestLive.volatileFail;
         nxt_stNvm    = selftestLive.nonvolatileFail;
         nxt_stLogic  = selftestLive.logicFail;
         nxt_stAnalog = selftestLive.analogFail;
         nxt_eccSec   = selftestLive.eccCorrected;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         stDone_ff   <= 1'b0;
         stVm_ff     <= 1'b0;
         stNvm_ff    <= 1'b0;
         stLogic_ff  <= 1'b0;
         stAnalog_ff <= 1'b0;
         eccSec_ff   <= 1'b0;
      end else begin
         stDone_ff   <= nxt_stDone;
         stVm_ff     <= nxt_stVm;
         stNvm_ff    <= nxt_stNvm;
         stLogic_ff  <= nxt_stLogic;
         stAnalog_ff <= nxt_stAnalog;
         eccSec_ff   <= nxt_eccSec;
      end
   end

   // fault requests toward the interrupt and reset output logic
   logic stIrqReq_ff;
   logic stRstReq_ff;
   logic nxt_stIrqReq;
   logic nxt_stRstReq;

   always_comb begin
      nxt_stIrqReq = stDone_ff & (stLogic_ff | stAnalog_ff);
      nxt_stRstReq = stDone_ff & (stLogic_ff | stAnalog_ff);
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         stIrqReq_ff <= 1'b0;
         stRstReq_ff <= 1'b0;
      end else begin
         stIrqReq_ff <= nxt_stIrqReq;
         stRstReq_ff <= nxt_stRstReq;
      end
   end

   // pad drivers from otp; open-drain only pulls low and releases for high
   logic [NUM_EN-1:0] enOut_ff;
   logic [NUM_EN-1:0] enOeN_ff;
   logic [NUM_EN-1:0] nxt_enOut;
   logic [NUM_EN-1:0] nxt_enOeN;
   logic              clkOut_ff;
   logic              clkOeN_ff;
   logic              xtalLoad_ff;
   logic              nxt_clkOut;
   logic              nxt_clkOeN;
   logic              nxt_xtalLoad;

   for (genvar i = 0; i < NUM_EN; i++) begin : g_endrv
      always_comb begin
         if (otpCfg.enableDriverType[i]) begin
            nxt_enOut[i] = seqLive.enableDrive[i];
            nxt_enOeN[i] = 1'b0;
         end else begin
            nxt_enOut[i] = 1'b0;
            nxt_enOeN[i] = seqLive.enableDrive[i];
         end
      end
   end

   always_comb begin
      nxt_clkOut   = otpCfg.slowclkDriverType ? slowClkIn : 1'b0;
      nxt_clkOeN   = otpCfg.slowclkDriverType ? 1'b0 : slowClkIn;
      nxt_xtalLoad = otpCfg.crystalLoadSelect;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         // released pads until the first cycle after reset
         enOut_ff    <= '0;
         enOeN_ff    <= '1;
         clkOut_ff   <= 1'b0;
         clkOeN_ff   <= 1'b1;
         xtalLoad_ff <= 1'b0;
      end else begin
         enOut_ff    <= nxt_enOut;
         enOeN_ff    <= nxt_enOeN;
         clkOut_ff   <= nxt_clkOut;
         clkOeN_ff   <= nxt_clkOeN;
         xtalLoad_ff <= nxt_xtalLoad;
      end
   end

   // interrupt events: rising edges of the captured conditions, early service taken straight from the live pulse
   logic                expPrev_ff;
   logic                eccPrev_ff;
   logic                donePrev_ff;
   logic [NUM_EVT-1:0]  evt;

   always_comb begin
      evt              = '0;
      evt[EV_EARLY]    = earlyEvt;
      evt[EV_EXPIRED]  = wdExpired_ff & ~expPrev_ff;
      evt[EV_ECC]      = eccSec_ff & ~eccPrev_ff;
      evt[EV_DONE]     = stDone_ff & ~donePrev_ff;
      evt[EV_FAIL]     = evt[EV_DONE] & (stVm_ff | stNvm_ff | stLogic_ff | stAnalog_ff);
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         expPrev_ff  <= 1'b0;
         eccPrev_ff  <= 1'b0;
         donePrev_ff <= 1'b0;
      end else begin
         expPrev_ff  <= wdExpired_ff;
         eccPrev_ff  <= eccSec_ff;
         donePrev_ff <= stDone_ff;
      end
   end

   // apb slave: one wait state, so every output is a flop
   logic                accessPhase;
   logic                hit;
   logic [31:0]         rdWord;
   logic                mapped;
   logic [31:0]         prdata_ff;
   logic                pready_ff;
   logic                pslverr_ff;
   logic [31:0]         nxt_prdata;
   logic                nxt_pready;
   logic                nxt_pslverr;
   logic [NUM_EVT-1:0]  intStatus_ff;
   logic [NUM_EVT-1:0]  intMask_ff;
   logic [NUM_EVT-1:0]  nxt_intStatus;
   logic [NUM_EVT-1:0]  nxt_intMask;
   logic                irq_ff;
   logic                nxt_irq;

   always_comb begin
      accessPhase = psel & penable;
      hit         = accessPhase & pready_ff;
      rdWord      = RESET_WORD;
      mapped      = 1'b1;
      unique case (paddr)
         PIN_STATUS_ADDR:   rdWord = pinStatus_ff;
         ENABLE_DRIVE_ADDR: rdWord = enDrive_ff;
         WDOG_BIST_ADDR: begin
            rdWord[WB_OPEN_BIT]   = wdOpen_ff;
            rdWord[WB_EARLY_BIT]  = wdEarly_ff;
            rdWord[WB_EXP_BIT]    = wdExpired_ff;
            rdWord[WB_DONE_BIT]   = stDone_ff;
            rdWord[WB_ECC_BIT]    = eccSec_ff;
            rdWord[WB_VM_BIT]     = stVm_ff;
            rdWord[WB_NVM_BIT]    = stNvm_ff;
            rdWord[WB_LOGIC_BIT]  = stLogic_ff;
            rdWord[WB_ANALOG_BIT] = stAnalog_ff;
         end
         OTP_CONFIG_ADDR: begin
            rdWord[OT_ENTYPE_LSB +: NUM_EN] = otpCfg.enableDriverType;
            rdWord[OT_XTAL_BIT]             = otpCfg.crystalLoadSelect;
            rdWord[OT_CLKPP_BIT]            = otpCfg.slowclkDriverType;
         end
         INT_STATUS_ADDR: rdWord[NUM_EVT-1:0] = intStatus_ff;
         INT_MASK_ADDR:   rdWord[NUM_EVT-1:0] = intMask_ff;
         default:         mapped = 1'b0;
      endcase
      // wait one cycle in access phase, then answer
      nxt_pready  = accessPhase & ~pready_ff;
      // an unmapped access returns zero data alongside the error, even for a write
      nxt_prdata  = (accessPhase & ~pready_ff & (~pwrite | ~mapped)) ? rdWord : prdata_ff;
      nxt_pslverr = accessPhase & ~pready_ff & ~mapped;
      // status and otp words take no write; reads clear nothing
      nxt_intMask = intMask_ff;
      if (hit & pwrite & (paddr == INT_MASK_ADDR)) begin
         nxt_intMask = pwdata[NUM_EVT-1:0];
      end
      // write one to clear; a new event in the same cycle wins
      nxt_intStatus = intStatus_ff;
      if (hit & pwrite & (paddr == INT_STATUS_ADDR)) begin
         nxt_intStatus = intStatus_ff & ~pwdata[NUM_EVT-1:0];
      end
      nxt_intStatus = nxt_intStatus | evt;
      nxt_irq       = |(nxt_intStatus & nxt_intMask);
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         prdata_ff    <= RESET_WORD;
         pready_ff    <= 1'b0;
         pslverr_ff   <= 1'b0;
         intStatus_ff <= '0;
         intMask_ff   <= MASK_RESET;
         irq_ff       <= 1'b0;
      end else begin
         prdata_ff    <= nxt_prdata;
         pready_ff    <= nxt_pready;
         pslverr_ff   <= nxt_pslverr;
         intStatus_ff <= nxt_intStatus;
         intMask_ff   <= nxt_intMask;
         irq_ff       <= nxt_irq;
      end
   end

   assign prdata           = prdata_ff;
   assign pready           = pready_ff;
   assign pslverr          = pslverr_ff;
   assign railEnOut        = enOut_ff;
   assign railEnOeN        = enOeN_ff;
   assign slowClkOut       = clkOut_ff;
   assign slowClkOeN       = clkOeN_ff;
   assign xtalInternalLoad = xtalLoad_ff;
   assign selftestIrqReq   = stIrqReq_ff;
   assign selftestRstReq   = stRstReq_ff;
   assign irqOut           = irq_ff;

endmodule : seq_status_bank

// [sim/apb_host_model.sv]
// partner: apb host issuing single word transfers for the bench
module apb_host_model (
   // clock
   input  wire logic        ref_clk,
   // apb request
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   // apb answer
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   // request held until pready is seen at an edge; the bench timeout ends a hang
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : apb_host_model

// [sim/seq_status_chk.sv]
// checker: apb answer timing, pad drive and self-test fault requests
module seq_status_chk (
   // clock and reset
   input wire logic                           ref_clk,
   input wire logic                           resetn,
   // apb
   input wire logic                           psel,
   input wire logic                           penable,
   input wire logic [31:0]                    prdata,
   input wire logic                           pready,
   input wire logic                           pslverr,
   // live inputs
   input wire seq_status_pkg::seq_live_s      seqLive,
   input wire seq_status_pkg::selftest_live_s selftestLive,
   input wire seq_status_pkg::otp_cfg_s       otpCfg,
   input wire logic                           slowClkIn,
   // outputs
   input wire logic [11:0]                    railEnOut,
   input wire logic [11:0]                    railEnOeN,
   input wire logic                           slowClkOut,
   input wire logic                           xtalInternalLoad,
   input wire logic                           selftestIrqReq,
   input wire logic                           selftestRstReq
);
   timeunit 1ns;
   timeprecision 1ns;
   import seq_status_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   chk_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("pslverr without pready or with data");
   chk_reset_vals: assert property ($past(!resetn) |-> !pready && railEnOeN == 12'hfff)
      else $error("reset values wrong");
   chk_rail_drive: assert property ($past(resetn) |-> railEnOut ==
      ($past(otpCfg.enableDriverType) & $past(seqLive.enableDrive)) && railEnOeN ==
      (~$past(otpCfg.enableDriverType) & $past(seqLive.enableDrive)))
      else $error("rail pad drive wrong");
   chk_slow_drive: assert property ($past(resetn) |->
      slowClkOut == ($past(otpCfg.slowclkDriverType) & $past(slowClkIn)))
      else $error("slow clock pad drive wrong");
   chk_crystal_load_select: assert property ($past(resetn) |-> xtalInternalLoad == $past(otpCfg.crystalLoadSelect))
      else $error("crystal load wrong");
   chk_fault_pair: assert property (selftestIrqReq == selftestRstReq)
      else $error("fault requests differ");
   chk_fault_clear: assert property (selftestLive.startPulse && !selftestLive.finishPulse
      |-> ##2 !selftestIrqReq)
      else $error("fault request kept after start");
   chk_fault_raise: assert property (selftestLive.finishPulse &&
      (selftestLive.logicFail || selftestLive.analogFail) |-> ##2 selftestIrqReq && selftestRstReq)
      else $error("fault request not raised after failed run");
   cover property (pslverr);
   cover property (selftestIrqReq);
   cover property (psel && penable && pready);
endmodule : seq_status_chk
bind seq_status_bank seq_status_chk u_seq_status_chk (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .seqLive(seqLive),
   .selftestLive(selftestLive), .otpCfg(otpCfg), .slowClkIn(slowClkIn), .railEnOut(railEnOut),
   .railEnOeN(railEnOeN), .slowClkOut(slowClkOut), .xtalInternalLoad(xtalInternalLoad),
   .selftestIrqReq(selftestIrqReq), .selftestRstReq(selftestRstReq));

// [sim/tb.sv]
// testbench: status, otp and interrupt checks of the status bank over apb
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import seq_status_pkg::*;
   logic ref_clk = 1'b0, resetn = 1'b0, sleepPin = 1'b0, activatePin = 1'b0, slowClkIn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, irqOut;
   logic slowClkOut, slowClkOeN, xtalInternalLoad, selftestIrqReq, selftestRstReq;
   logic [11:0] paddr, railEnOut, railEnOeN;
   logic [31:0] pwdata, prdata;
   seq_live_s seqLive = '0;
   wdog_live_s wdogLive = '0;
   selftest_live_s selftestLive = '0;
   otp_cfg_s otpCfg = '0;
   int mismatches = 0, compares = 0, cyc = 0;
   always #50 ref_clk = ~ref_clk;
   apb_host_model u_apb_host_model (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   seq_status_bank u_seq_status_bank (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .seqLive(seqLive), .wdogLive(wdogLive), .selftestLive(selftestLive),
      .otpCfg(otpCfg), .sleepPin(sleepPin), .activatePin(activatePin), .slowClkIn(slowClkIn),
      .railEnOut(railEnOut), .railEnOeN(railEnOeN), .slowClkOut(slowClkOut), .slowClkOeN(slowClkOeN),
      .xtalInternalLoad(xtalInternalLoad), .selftestIrqReq(selftestIrqReq),
      .selftestRstReq(selftestRstReq), .irqOut(irqOut));
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   // generous ceiling; the whole sequence needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : step
   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
      logic [31:0] q;
      logic er;
      u_apb_host_model.xfer(1'b0, a, 32'h0, q, er);
      `CHK("rdata", e, q)
      `CHK("pslverr", ee, er)
   endtask : rdc
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic er;
      u_apb_host_model.xfer(1'b1, a, d, q, er);
   endtask : wr
   task automatic t_pins();
      for (int i = 0; i < 8; i++) begin
         seqLive.sequencerState <= seq_state_e'(3'(i));
         seqLive.irqAsserted <= i[0];
         seqLive.rstAsserted <= i[1];
         sleepPin <= i[2];
         activatePin <= ~i[0];
         step(4);
         rdc(PIN_STATUS_ADDR, {25'h0, 3'(i), ~i[0], i[2], i[1], i[0]}, 1'b0);
      end
   endtask : t_pins
   task automatic t_drive();
      seqLive.enableDrive <= 12'ha5c;
      otpCfg.enableDriverType <= 12'h0ff;
      step(2);
      `CHK("railEnOut", 12'h05c, railEnOut)
      `CHK("railEnOeN", 12'ha00, railEnOeN)
      rdc(ENABLE_DRIVE_ADDR, 32'h0000_0a5c, 1'b0);
      wr(ENABLE_DRIVE_ADDR, 32'hffff_ffff);
      rdc(ENABLE_DRIVE_ADDR, 32'h0000_0a5c, 1'b0);
   endtask : t_drive
   task automatic t_otp();
      otpCfg.crystalLoadSelect <= 1'b1;
      slowClkIn <= 1'b1;
      step(2);
      `CHK("xtalLoad", 1'b1, xtalInternalLoad)
      `CHK("slowOeN", 1'b1, slowClkOeN)
      otpCfg.slowclkDriverType <= 1'b1;
      step(2);
      `CHK("slowOut", 1'b1, slowClkOut)
      `CHK("slowOeN", 1'b0, slowClkOeN)
      rdc(OTP_CONFIG_ADDR, 32'h0000_30ff, 1'b0);
      wr(OTP_CONFIG_ADDR, 32'h0000_0000);
      rdc(OTP_CONFIG_ADDR, 32'h0000_30ff, 1'b0);
      rdc(12'h020, 32'h0, 1'b1);
   endtask : t_otp
   task automatic t_wdog();
      wdogLive.servicePulse <= 1'b1;
      step(1);
      wdogLive.servicePulse <= 1'b0;
      step(2);
      rdc(WDOG_BIST_ADDR, 32'h2, 1'b0);
      rdc(WDOG_BIST_ADDR, 32'h2, 1'b0);
      wr(INT_MASK_ADDR, 32'h1);
      step(2);
      `CHK("irqOut", 1'b1, irqOut)
      wr(INT_STATUS_ADDR, 32'h1);
      step(2);
      `CHK("irqOut", 1'b0, irqOut)
      wdogLive.windowOpen <= 1'b1;
      wdogLive.servicePulse <= 1'b1;
      step(1);
      wdogLive.servicePulse <= 1'b0;
      wdogLive.closeExpired <= 1'b1;
      step(3);
      rdc(WDOG_BIST_ADDR, 32'h5, 1'b0);
      rdc(INT_STATUS_ADDR, 32'h2, 1'b0);
      `CHK("irqMasked", 1'b0, irqOut)
      wr(INT_STATUS_ADDR, 32'h1f);
      wdogLive.closeExpired <= 1'b0;
   endtask : t_wdog
   task automatic t_selftest();
      selftestLive.startPulse <= 1'b1;
      step(1);
      selftestLive.startPulse <= 1'b0;
      step(2);
      rdc(WDOG_BIST_ADDR, 32'h1, 1'b0);
      selftestLive.logicFail <= 1'b1;
      selftestLive.eccCorrected <= 1'b1;
      selftestLive.volatileFail <= 1'b1;
      selftestLive.finishPulse <= 1'b1;
      step(1);
      selftestLive.finishPulse <= 1'b0;
      step(3);
      rdc(WDOG_BIST_ADDR, 32'h0b9, 1'b0);
      rdc(INT_STATUS_ADDR, 32'h1c, 1'b0);
      `CHK("irqReq", 1'b1, selftestIrqReq)
      `CHK("rstReq", 1'b1, selftestRstReq)
      // start pulse only, every result level low
      selftestLive <= selftest_live_s'(7'h40);
      step(1);
      selftestLive.startPulse <= 1'b0;
      selftestLive.nonvolatileFail <= 1'b1;
      selftestLive.analogFail <= 1'b1;
      step(3);
      `CHK("irqReq", 1'b0, selftestIrqReq)
      selftestLive.finishPulse <= 1'b1;
      step(1);
      selftestLive.finishPulse <= 1'b0;
      step(3);
      rdc(WDOG_BIST_ADDR, 32'h149, 1'b0);
      `CHK("rstReq", 1'b1, selftestRstReq)
   endtask : t_selftest
   initial begin
      step(20);
      resetn <= 1'b1;
      step(2);
      t_pins();
      t_drive();
      t_otp();
      t_wdog();
      t_selftest();
      close_out();
   end
endmodule : tb
